/* File: tdmba_consts.svh */
`ifndef TDMBA_CONSTS_SVH
`define TDMBA_CONSTS_SVH

// Register byte offsets
`define TDMBA_OFF_BOE 8'h00
`define TDMBA_OFF_TXSO 8'h04
`define TDMBA_OFF_RXSO 8'h08
`define TDMBA_OFF_CTL 8'h0C
`define TDMBA_OFF_TXD 8'h10
`define TDMBA_OFF_RXD 8'h14

// bit_offset_edge_control fields
`define TDMBA_RX_EDGE_BIT 0
`define TDMBA_RX_BOF_LSB 1
`define TDMBA_TX_EDGE_BIT 4
`define TDMBA_TX_BOF_LSB 5

// Slot offset control fields (tx and rx alike)
`define TDMBA_SLOT_LSB 0
`define TDMBA_ORDER_BIT 6
`define TDMBA_INV_BIT 7

// link_control and rx_data fields
`define TDMBA_CTL_HWY_BIT 0
`define TDMBA_CTL_PINB_BIT 1
`define TDMBA_RXD_NEW_BIT 8

// Reset values
`define TDMBA_RST_BOE 8'h01
`define TDMBA_RST_TXSO 8'h40
`define TDMBA_RST_RXSO 8'h40
`define TDMBA_RST_CTL 8'h00
`define TDMBA_RST_TXD 8'h00

`endif

/* File: tdmba_pkg.sv */
package tdmba_pkg;
   typedef logic [7:0] tdmba_byte_t;
   typedef logic [5:0] tdmba_slot_t;
   typedef enum logic [1:0] {TDMBA_WAIT, TDMBA_OFFSET, TDMBA_DATA} tdmba_lane_e;
endpackage : tdmba_pkg

/* File: tdmba_lane.sv */
module tdmba_lane (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic restart,
   input wire logic [2:0] bit_offset,
   input wire logic [5:0] slot_offset,
   output logic bit_valid,
   output logic [2:0] bit_idx,
   output logic slot_ok,
   output tdmba_pkg::tdmba_slot_t vslot
);
   tdmba_pkg::tdmba_lane_e state_r;
   logic [2:0] cnt_r;
   logic [2:0] bit_r;
   tdmba_pkg::tdmba_slot_t slot_r;

   ////////////////////////////////////////////////////////////////////////////////
   // Each frame sync starts counting afresh; no position is valid before the first one
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= tdmba_pkg::TDMBA_WAIT;
         cnt_r <= 3'h0;
         bit_r <= 3'h0;
         slot_r <= 6'h00;
      end else if (restart) begin
         state_r <= (bit_offset == 3'h0) ? tdmba_pkg::TDMBA_DATA : tdmba_pkg::TDMBA_OFFSET;
         cnt_r <= bit_offset;
         bit_r <= 3'h0;
         slot_r <= 6'h00;
      end else begin
         case (state_r)
            tdmba_pkg::TDMBA_WAIT: begin
               state_r <= tdmba_pkg::TDMBA_WAIT;
            end
            tdmba_pkg::TDMBA_OFFSET: begin
               cnt_r <= cnt_r - 3'h1;
               if (cnt_r == 3'h1) begin
                  state_r <= tdmba_pkg::TDMBA_DATA;
               end
            end
            tdmba_pkg::TDMBA_DATA: begin
               bit_r <= bit_r + 3'h1;
               if (bit_r == 3'h7) begin
                  slot_r <= slot_r + 6'h01;
               end
            end
            default: begin
               state_r <= tdmba_pkg::TDMBA_WAIT;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   assign bit_valid = (state_r == tdmba_pkg::TDMBA_DATA);
   assign bit_idx = bit_r;
   assign slot_ok = (slot_r >= slot_offset);
   assign vslot = slot_r - slot_offset;
endmodule : tdmba_lane

/* File: tdmba_top.sv */
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`include "tdmba_consts.svh"

module tdmba_top #(
   parameter int ADDR_W = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic tx_serial_clock,
   input wire logic frame_sync,
   input wire logic serial_in_a,
   input wire logic serial_in_b,
   output logic tx_data_out,
   output logic tx_data_oe
);
   function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
      logic [7:0] a8;
      a8 = a[7:0];
      addr_hit = (a8 == `TDMBA_OFF_BOE) || (a8 == `TDMBA_OFF_TXSO) ||
                 (a8 == `TDMBA_OFF_RXSO) || (a8 == `TDMBA_OFF_CTL) ||
                 (a8 == `TDMBA_OFF_TXD) || (a8 == `TDMBA_OFF_RXD);
   endfunction : addr_hit

   logic [7:0] boe_r;
   logic [7:0] txso_r;
   logic [7:0] rxso_r;
   logic [7:0] ctl_r;
   tdmba_pkg::tdmba_byte_t txd_r;
   tdmba_pkg::tdmba_byte_t rxd_r;
   logic rx_new_r;
   logic tx_tog_r;
   logic [2:0] rx_tog_q;
   tdmba_pkg::tdmba_byte_t rx_hold_l;
   logic rx_tog_l;
   logic [31:0] prdata_r;
   logic pready_r;
   logic pslverr_r;
   logic [31:0] rd_mux;
   logic acc;
   logic done;
   logic wr;

   ////////////////////////////////////////////////////////////////////////////////
   // APB slave: one wait state, so read data is settled from a flop
   assign acc = psel & penable & ~pready_r;
   assign done = psel & penable & pready_r;
   assign wr = done & pwrite & addr_hit(paddr);

   always_comb begin
      rd_mux = 32'h0000_0000;
      case (paddr[7:0])
         `TDMBA_OFF_BOE: rd_mux[7:0] = boe_r;
         `TDMBA_OFF_TXSO: rd_mux[7:0] = txso_r;
         `TDMBA_OFF_RXSO: rd_mux[7:0] = rxso_r;
         `TDMBA_OFF_CTL: rd_mux[7:0] = ctl_r;
         `TDMBA_OFF_TXD: rd_mux[7:0] = txd_r;
         `TDMBA_OFF_RXD: begin
            rd_mux[7:0] = rxd_r;
            rd_mux[`TDMBA_RXD_NEW_BIT] = rx_new_r;
         end
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
      end else begin
         pready_r <= acc;
         pslverr_r <= acc & ~addr_hit(paddr);
         prdata_r <= (acc & ~pwrite) ? rd_mux : 32'h0000_0000;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         boe_r <= `TDMBA_RST_BOE;
         txso_r <= `TDMBA_RST_TXSO;
         rxso_r <= `TDMBA_RST_RXSO;
         ctl_r <= `TDMBA_RST_CTL;
         txd_r <= `TDMBA_RST_TXD;
         tx_tog_r <= 1'b0;
      end else if (wr) begin
         case (paddr[7:0])
            `TDMBA_OFF_BOE: boe_r <= pwdata[7:0];
            `TDMBA_OFF_TXSO: txso_r <= pwdata[7:0];
            `TDMBA_OFF_RXSO: rxso_r <= pwdata[7:0];
            `TDMBA_OFF_CTL: ctl_r <= {6'h00, pwdata[1:0]};
            `TDMBA_OFF_TXD: begin
               txd_r <= pwdata[7:0];
               tx_tog_r <= ~tx_tog_r;
            end
            default: ctl_r <= ctl_r;
         endcase
      end
   end

   // Received slot byte arrives by toggle; a new byte beats a read clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_tog_q <= 3'h0;
         rxd_r <= 8'h00;
         rx_new_r <= 1'b0;
      end else begin
         rx_tog_q <= {rx_tog_q[1:0], rx_tog_l};
         if (rx_tog_q[2] != rx_tog_q[1]) begin
            rxd_r <= rx_hold_l;
            rx_new_r <= 1'b1;
         end else if (done & ~pwrite & (paddr[7:0] == `TDMBA_OFF_RXD)) begin
            rx_new_r <= 1'b0;
         end
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;

   ////////////////////////////////////////////////////////////////////////////////
   // Link domain. Each setting bit is synchronised on its own, then taken over
   // as a whole at frame start, so a mid-frame write cannot cut a slot.
   logic [1:0] lrst_q;
   logic link_rst_n;
   logic [25:0] cfg_q1;
   logic [25:0] cfg_q2;
   logic [25:0] cfg_f;
   logic [2:0] tx_tog_q;
   tdmba_pkg::tdmba_byte_t tx_byte_l;
   logic fs_r;
   logic rx_pos_r;
   logic rx_neg_r;
   tdmba_pkg::tdmba_byte_t rx_sh_l;
   logic tx_pos_r;
   logic tx_pos_oe_r;
   logic tx_neg_r;
   logic tx_neg_oe_r;

   always_ff @(posedge tx_serial_clock or negedge presetn) begin
      if (!presetn) begin
         lrst_q <= 2'h0;
      end else begin
         lrst_q <= {lrst_q[0], 1'b1};
      end
   end
   assign link_rst_n = lrst_q[1];

   always_ff @(posedge tx_serial_clock or negedge link_rst_n) begin
      if (!link_rst_n) begin
         cfg_q1 <= {2'h0, `TDMBA_RST_RXSO, `TDMBA_RST_TXSO, `TDMBA_RST_BOE};
         cfg_q2 <= {2'h0, `TDMBA_RST_RXSO, `TDMBA_RST_TXSO, `TDMBA_RST_BOE};
         tx_tog_q <= 3'h0;
         tx_byte_l <= 8'h00;
      end else begin
         cfg_q1 <= {ctl_r[1:0], rxso_r, txso_r, boe_r};
         cfg_q2 <= cfg_q1;
         tx_tog_q <= {tx_tog_q[1:0], tx_tog_r};
         if (tx_tog_q[2] != tx_tog_q[1]) begin
            tx_byte_l <= txd_r;
         end
      end
   end

   // The bit offsets are read by the lanes at this same restart edge
   always_ff @(posedge tx_serial_clock or negedge link_rst_n) begin
      if (!link_rst_n) begin
         cfg_f <= {2'h0, `TDMBA_RST_RXSO, `TDMBA_RST_TXSO, `TDMBA_RST_BOE};
      end else if (fs_r) begin
         cfg_f <= cfg_q2;
      end
   end

   logic rx_edge;
   logic tx_edge;
   logic hwy_on;
   logic pin_b;
   logic rx_msb_first;
   logic tx_msb_first;
   assign rx_edge = cfg_f[`TDMBA_RX_EDGE_BIT];
   assign tx_edge = cfg_f[`TDMBA_TX_EDGE_BIT];
   assign hwy_on = cfg_f[24 + `TDMBA_CTL_HWY_BIT];
   assign pin_b = cfg_f[24 + `TDMBA_CTL_PINB_BIT];
   assign rx_msb_first = hwy_on & ~cfg_f[16 + `TDMBA_ORDER_BIT];
   assign tx_msb_first = hwy_on & ~cfg_f[8 + `TDMBA_ORDER_BIT];

   // Serial pins are sampled by the link clock itself, so no extra stages
   always_ff @(posedge tx_serial_clock or negedge link_rst_n) begin
      if (!link_rst_n) begin
         fs_r <= 1'b0;
         rx_pos_r <= 1'b0;
      end else begin
         fs_r <= frame_sync;
         rx_pos_r <= pin_b ? serial_in_b : serial_in_a;
      end
   end

   always_ff @(negedge tx_serial_clock or negedge link_rst_n) begin
      if (!link_rst_n) begin
         rx_neg_r <= 1'b0;
      end else begin
         rx_neg_r <= pin_b ? serial_in_b : serial_in_a;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Receive: the falling-edge sample is half a period younger, so the first
   // receivable bit sits one position later with the falling edge
   logic rx_bit;
   logic rx_valid;
   logic [2:0] rx_idx;
   logic rx_slot_ok;
   tdmba_pkg::tdmba_slot_t rx_vslot;
   tdmba_pkg::tdmba_byte_t rx_full;

   assign rx_bit = (rx_edge ? rx_pos_r : rx_neg_r) ^ cfg_f[16 + `TDMBA_INV_BIT];
   assign rx_full = rx_msb_first ? {rx_sh_l[6:0], rx_bit} : {rx_bit, rx_sh_l[7:1]};

   tdmba_lane u_rx_lane (
      .clk(tx_serial_clock),
      .rst_n(link_rst_n),
      .restart(fs_r),
      .bit_offset(cfg_q2[`TDMBA_RX_BOF_LSB +: 3]),
      .slot_offset(cfg_f[16 + `TDMBA_SLOT_LSB +: 6]),
      .bit_valid(rx_valid),
      .bit_idx(rx_idx),
      .slot_ok(rx_slot_ok),
      .vslot(rx_vslot)
   );

   always_ff @(posedge tx_serial_clock or negedge link_rst_n) begin
      if (!link_rst_n) begin
         rx_sh_l <= 8'h00;
         rx_hold_l <= 8'h00;
         rx_tog_l <= 1'b0;
      end else if (rx_valid) begin
         rx_sh_l <= rx_full;
         if ((rx_idx == 3'h7) && rx_slot_ok && (rx_vslot == 6'h00)) begin
            rx_hold_l <= rx_full;
            rx_tog_l <= ~rx_tog_l;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Transmit: the byte goes out in virtual slot 0, pin released elsewhere
   logic tx_valid;
   logic [2:0] tx_idx;
   logic tx_slot_ok;
   tdmba_pkg::tdmba_slot_t tx_vslot;
   logic tx_bit;

   tdmba_lane u_tx_lane (
      .clk(tx_serial_clock),
      .rst_n(link_rst_n),
      .restart(fs_r),
      .bit_offset(cfg_q2[`TDMBA_TX_BOF_LSB +: 3]),
      .slot_offset(cfg_f[8 + `TDMBA_SLOT_LSB +: 6]),
      .bit_valid(tx_valid),
      .bit_idx(tx_idx),
      .slot_ok(tx_slot_ok),
      .vslot(tx_vslot)
   );

   assign tx_bit = tx_msb_first ? tx_byte_l[3'h7 - tx_idx] : tx_byte_l[tx_idx];

   always_ff @(posedge tx_serial_clock or negedge link_rst_n) begin
      if (!link_rst_n) begin
         tx_pos_r <= 1'b0;
         tx_pos_oe_r <= 1'b0;
      end else begin
         tx_pos_r <= tx_bit ^ cfg_f[8 + `TDMBA_INV_BIT];
         tx_pos_oe_r <= tx_valid & tx_slot_ok & (tx_vslot == 6'h00);
      end
   end

   // Falling-edge copy: half a period later, which moves the first
   // transmittable position with the edge choice
   always_ff @(negedge tx_serial_clock or negedge link_rst_n) begin
      if (!link_rst_n) begin
         tx_neg_r <= 1'b0;
         tx_neg_oe_r <= 1'b0;
      end else begin
         tx_neg_r <= tx_pos_r;
         tx_neg_oe_r <= tx_pos_oe_r;
      end
   end

   // A single flop cannot launch on both edges, so the edge is chosen by a mux
   assign tx_data_out = tx_edge ? tx_pos_r : tx_neg_r;
   assign tx_data_oe = tx_edge ? tx_pos_oe_r : tx_neg_oe_r;
endmodule : tdmba_top

/* File: tdmba_monitor.sv */
module tdmba_monitor #(
   parameter int ADDR_W = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic tx_serial_clock,
   input wire logic frame_sync,
   input wire logic tx_data_oe
);
   logic mapped;
   // Six aligned words from offset zero
   assign mapped = (paddr[1:0] == 2'h0) && (paddr < ADDR_W'(8'h18));
   ////////////////////////////////////////////////////////////////////////////
   property p_ready_on_time;
      @(posedge pclk) disable iff (!presetn) psel && $rose(penable) |=> pready;
   endproperty
   a_ready_on_time: assert property (p_ready_on_time) else $error("pready late");
   property p_ready_one;
      @(posedge pclk) disable iff (!presetn) pready |=> !pready;
   endproperty
   a_ready_one: assert property (p_ready_one) else $error("pready too long");
   property p_ready_in_access;
      @(posedge pclk) disable iff (!presetn) pready |-> psel && penable;
   endproperty
   a_ready_in_access: assert property (p_ready_in_access) else $error("pready outside access");
   property p_err_unmapped;
      @(posedge pclk) disable iff (!presetn) pready && !mapped |-> pslverr;
   endproperty
   a_err_unmapped: assert property (p_err_unmapped) else $error("no error on hole");
   property p_err_mapped;
      @(posedge pclk) disable iff (!presetn) pready && mapped |-> !pslverr;
   endproperty
   a_err_mapped: assert property (p_err_mapped) else $error("error on register");
   property p_rdata_idle;
      @(posedge pclk) disable iff (!presetn) !pready |-> prdata == 32'h0000_0000;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("prdata not zero");
   ////////////////////////////////////////////////////////////////////////////
   property p_slot_len;
      @(posedge tx_serial_clock) disable iff (!presetn)
         $rose(tx_data_oe) |-> tx_data_oe [*8] ##1 !tx_data_oe;
   endproperty
   a_slot_len: assert property (p_slot_len) else $error("slot not 8 bits");
   property p_sync_quiet;
      @(posedge tx_serial_clock) disable iff (!presetn) frame_sync |=> !tx_data_oe [*2];
   endproperty
   a_sync_quiet: assert property (p_sync_quiet) else $error("drive too early");
   property p_one_slot;
      @(posedge tx_serial_clock) disable iff (!presetn) $fell(tx_data_oe) |-> !tx_data_oe [*8];
   endproperty
   a_one_slot: assert property (p_one_slot) else $error("second slot driven");
endmodule : tdmba_monitor

/* File: tdmba_hwy_model.sv */
module tdmba_hwy_model #(
   parameter int FRAME_BITS = 64
) (
   input wire logic link_clk,
   input wire logic rx_edge,
   input wire logic tx_edge,
   input wire logic [63:0] rx_frame,
   input wire logic tx_data_out,
   input wire logic tx_data_oe,
   output logic frame_sync,
   output logic serial_in_a,
   output logic serial_in_b,
   output logic [7:0] done_byte,
   output int done_pos
);
   timeunit 1ns;
   timeprecision 100ps;
   int cnt = 0;
   int nxt;
   int bits = 0;
   int pos = 0;
   logic [7:0] cur = 8'h00;
   initial begin
      frame_sync = 1'b0;
      serial_in_a = 1'b0;
      done_byte = 8'h00;
      done_pos = -1;
   end
   assign serial_in_b = ~serial_in_a;
   assign nxt = (cnt == FRAME_BITS - 1) ? 0 : cnt + 1;
   // Position counted in half link periods from the sync edge
   task automatic grab(input int half);
      if (tx_data_oe === 1'b1 && bits < 8) begin
         if (bits == 0) pos = half;
         cur[bits] = tx_data_out;
         bits++;
      end
   endtask : grab
   ////////////////////////////////////////////////////////////////////////////
   // Free running clock, one sync per frame; data launched away from sampling edge
   always @(posedge link_clk) begin
      if (!tx_edge) grab(2 * cnt + 2);
      if (nxt == 0) begin
         done_byte <= cur;
         done_pos <= (bits == 8) ? pos : -1;
         bits = 0;
      end
      frame_sync <= (nxt == FRAME_BITS - 1);
      if (!rx_edge) serial_in_a <= rx_frame[nxt];
      cnt <= nxt;
   end
   always @(negedge link_clk) begin
      if (tx_edge) grab(2 * cnt + 1);
      if (rx_edge) serial_in_a <= rx_frame[cnt];
   end
endmodule : tdmba_hwy_model

/* File: tb_top.sv */
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic pclk, presetn, psel, penable, pwrite, lclk, rx_edge, tx_edge;
   logic pready, pslverr, fs, sa, sb, txd, txoe;
   logic [7:0] paddr, done_byte;
   logic [31:0] pwdata, prdata;
   logic [63:0] rx_frame;
   int done_pos, tick = 0, miscompares = 0, check_count = 0;
   tdmba_top u_tdmba_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .tx_serial_clock(lclk), .frame_sync(fs), .serial_in_a(sa),
      .serial_in_b(sb), .tx_data_out(txd), .tx_data_oe(txoe));
   tdmba_hwy_model u_tdmba_hwy_model (.link_clk(lclk), .rx_edge(rx_edge), .tx_edge(tx_edge),
      .rx_frame(rx_frame), .tx_data_out(txd), .tx_data_oe(txoe), .frame_sync(fs),
      .serial_in_a(sa), .serial_in_b(sb), .done_byte(done_byte), .done_pos(done_pos));
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
         miscompares++;
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] rd, output logic err);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   function automatic logic [7:0] wire_of(input logic [7:0] b, input logic lsbf, input logic inv);
      for (int i = 0; i < 8; i++) wire_of[i] = (lsbf ? b[i] : b[7-i]) ^ inv;
   endfunction : wire_of
   task automatic end_sim();
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : end_sim
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_regs();
      logic [31:0] rd;
      logic e;
      logic [7:0] rv [5] = '{8'h01, 8'h40, 8'h40, 8'h00, 8'h00};
      // Receive data register skipped: frames land right after reset
      for (int i = 0; i < 5; i++) begin
         apb(1'b0, 8'(4 * i), 32'h0000_0000, rd, e);
         chk(rd, {24'h00_0000, rv[i]});
      end
      apb(1'b0, 8'h18, 32'h0000_0000, rd, e);
      chk({31'h0, e}, 32'h0000_0001);
      apb(1'b1, 8'h14, 32'h0000_00FF, rd, e);
      chk({31'h0, e}, 32'h0000_0000);
   endtask : t_regs
   task automatic t_link(input logic [7:0] boe, tso, rso, ctl, tb, rb);
      logic [31:0] rd;
      logic e;
      logic [63:0] f;
      logic [7:0] w;
      f = 64'h3C5A_96E1_0FF0_A55A;
      w = wire_of(rb, !ctl[0] || rso[6], rso[7]);
      // Falling-edge sampling takes its first bit one frame position later
      for (int i = 0; i < 8; i++) f[8 * rso[5:0] + boe[3:1] + !boe[0] + i] = w[i] ^ ctl[1];
      rx_frame <= f;
      rx_edge <= boe[0];
      tx_edge <= boe[4];
      apb(1'b1, 8'h00, {24'h00_0000, boe}, rd, e);
      apb(1'b1, 8'h04, {24'h00_0000, tso}, rd, e);
      apb(1'b1, 8'h08, {24'h00_0000, rso}, rd, e);
      apb(1'b1, 8'h0C, {24'h00_0000, ctl}, rd, e);
      apb(1'b1, 8'h10, {24'h00_0000, tb}, rd, e);
      repeat (40) @(posedge pclk);
      chk({24'h00_0000, done_byte}, {24'h00_0000, wire_of(tb, !ctl[0] || tso[6], tso[7])});
      chk(32'(done_pos), 32'(5 + 2 * boe[7:5] + 16 * tso[5:0] + !boe[4]));
      apb(1'b0, 8'h14, 32'h0000_0000, rd, e);
      chk(rd, {23'h00_0000, 1'b1, rb});
      apb(1'b0, 8'h04, 32'h0000_0000, rd, e);
      chk(rd, {24'h00_0000, tso});
   endtask : t_link
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   // Link clock unrelated in phase to the bus clock
   initial begin
      lclk = 1'b0;
      #3.2;
      forever #7.5 lclk = ~lclk;
   end
   always @(posedge pclk) begin
      tick++;
      if (tick == 3000) begin
         miscompares++;
         end_sim();
      end
   end
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      rx_frame = 64'h3C5A_96E1_0FF0_A55A;
      rx_edge = 1'b1;
      tx_edge = 1'b0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_link(8'h01, 8'h40, 8'h40, 8'h00, 8'hB4, 8'h2D);
      t_link(8'hB6, 8'h82, 8'h81, 8'h01, 8'h96, 8'hC3);
      t_link(8'hFF, 8'h41, 8'h46, 8'h03, 8'h5A, 8'hE1);
      t_link(8'h24, 8'h83, 8'h05, 8'h00, 8'h1E, 8'h78);
      end_sim();
   end
endmodule : tb_top

bind tdmba_top tdmba_monitor #(.ADDR_W(ADDR_W)) u_tdmba_monitor (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .tx_serial_clock(tx_serial_clock),
   .frame_sync(frame_sync), .tx_data_oe(tx_data_oe));
